// file: pio6_port.sv
// Seven-pin general port with bus strobe, bus release and wait pin muxing, AXI4-Lite slave.
// Assumes a bus controller supplies strobe levels and pins are resolved outside from enables.
// Notes on behaviour
// RQ1: Store output value per pin, drive outputs.
// RQ2: Read returns pin level where direction 0.
// RQ3: Read returns stored value where direction 1.
// RQ4: Bit seven ignores writes, reads one.
// RQ5: Data resets to 80 on reset, standby.
// RQ6: Software standby keeps data register contents.
// RQ7: Modes 1-6: pins 6..3 are strobes.
// RQ8: Release enable makes pin2 grant, pin1 request.
// RQ9: Pin0 is wait input when selected.
// RQ10: Mode 7: all pins plain general I/O; pin 0 still becomes the wait input when wait is selected.
// RQ11: Direction write-only, reads ones, resets 80.
// RQ12: Bus-function pins take controller level, fixed direction.
`timescale 1ns/10ps
`include "pio6_defs.svh"
module pio6_port
   import pio6_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Standby controls.
   input wire logic hw_standby,
   input wire logic sw_standby,
   // AXI4-Lite slave.
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Bus controller side.
   input wire logic low_byte_write_strobe,
   input wire logic high_byte_write_strobe,
   input wire logic read_strobe,
   input wire logic address_strobe,
   input wire logic bus_grant_ack,
   output logic bus_request_in,
   output logic wait_in,
   // Pins.
   input wire logic [6:0] pin_in,
   output logic [6:0] pin_out,
   output logic [6:0] pin_oe
);
   logic [6:0] port_six_output_value;
   logic [6:0] port_six_direction;
   logic [2:0] op_mode;
   logic bus_release_enable;
   logic wait_mode_select_high;
   logic [7:0] wait_state_enable_bits;
   logic [6:0] pin_s1, pin_s2;
   logic [11:0] aw_addr;
   logic aw_held, w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   pio6_bus_e wst;
   logic expanded, wait_sel, do_write;
   logic [6:0] rd_port;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction : hit

   // Pins come from another domain, so two stages before any use.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pin_s1 <= 7'h00;
         pin_s2 <= 7'h00;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   assign expanded = (op_mode != `PIO6_MODE_SINGLE);
   assign wait_sel = wait_mode_select_high || (wait_state_enable_bits != `PIO6_WCE_ALL); // [RQ9]

   // Write channel: address and data accepted in either order, one response.
   assign s_axi_awready = (wst == pio6_idle) && !aw_held;
   assign s_axi_wready = (wst == pio6_idle) && !w_held;
   assign do_write = (wst == pio6_idle) && aw_held && w_held;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         wst <= pio6_idle;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wst <= pio6_wresp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (hit(aw_addr, `PIO6_DIR_OFS) || hit(aw_addr, `PIO6_DATA_OFS)
               || hit(aw_addr, `PIO6_CTRL_OFS)) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst <= pio6_idle;
         end
      end
   end

   // Hardware standby reinitialises like reset; software standby simply holds.
   always_ff @(posedge sys_clk) begin
      if (!rstn || hw_standby) begin
         port_six_output_value <= 7'(`PIO6_RST_VAL); // [RQ5]
         port_six_direction <= 7'(`PIO6_RST_VAL); // [RQ11]
      end else if (do_write && w_strb[0] && !sw_standby) begin // [RQ6]
         if (hit(aw_addr, `PIO6_DATA_OFS))
            port_six_output_value <= w_data[6:0]; // [RQ1] [RQ4]
         if (hit(aw_addr, `PIO6_DIR_OFS))
            port_six_direction <= w_data[6:0]; // [RQ11]
      end
   end

   // Bus-controller settings; mode is software-set here rather than strapped.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         op_mode <= `PIO6_MODE_RST;
         bus_release_enable <= 1'b0;
         wait_mode_select_high <= 1'b0;
         wait_state_enable_bits <= `PIO6_WCE_RST;
      end else if (do_write && hit(aw_addr, `PIO6_CTRL_OFS)) begin
         if (w_strb[0]) begin
            op_mode <= w_data[2:0];
            bus_release_enable <= w_data[4];
            wait_mode_select_high <= w_data[5];
         end
         if (w_strb[1])
            wait_state_enable_bits <= w_data[15:8];
      end
   end

   // Per-pin read value: pin level for inputs, stored value for outputs.
   assign rd_port = (port_six_direction & port_six_output_value)
      | (~port_six_direction & pin_s2); // [RQ2] [RQ3]

   // Read channel.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (hit(s_axi_araddr, `PIO6_DATA_OFS))
            s_axi_rdata <= {24'h000000, 1'b1, rd_port}; // [RQ4]
         else if (hit(s_axi_araddr, `PIO6_DIR_OFS))
            s_axi_rdata <= 32'h0000_00ff; // [RQ11]
         else if (hit(s_axi_araddr, `PIO6_CTRL_OFS))
            s_axi_rdata <= {16'h0000, wait_state_enable_bits, 2'h0, wait_mode_select_high,
               bus_release_enable, 1'b0, op_mode};
         else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Pin muxing. Strobe pins follow the controller level and are always driven.
   always_comb begin
      pin_out = port_six_output_value; // [RQ1] [RQ10]
      pin_oe = port_six_direction;
      if (expanded) begin
         pin_out[6:3] = {low_byte_write_strobe, high_byte_write_strobe, read_strobe,
            address_strobe}; // [RQ7] [RQ12]
         pin_oe[6:3] = 4'hf; // [RQ7]
         if (bus_release_enable) begin
            pin_out[2] = bus_grant_ack; // [RQ8] [RQ12]
            pin_oe[2] = 1'b1;
            pin_out[1] = 1'b0;
            pin_oe[1] = 1'b0; // [RQ8]
         end
      end
      if (wait_sel) begin
         pin_out[0] = 1'b0;
         pin_oe[0] = 1'b0; // [RQ9] [RQ12]
      end
   end

   // Unselected functions read inactive (high) so the controller sees no request.
   assign bus_request_in = (expanded && bus_release_enable) ? pin_s2[1] : 1'b1; // [RQ8]
   assign wait_in = wait_sel ? pin_s2[0] : 1'b1; // [RQ9]

   a_strobe_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
      expanded |-> (pin_oe[6:3] == 4'hf && pin_out[3] == address_strobe)) // [RQ7]
      else $error("strobe pin not driven by controller");
   a_data_rbit: assert property (@(posedge sys_clk) disable iff (!rstn)
      (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `PIO6_DATA_OFS))
      |=> s_axi_rdata[7] && s_axi_rdata[6:0] == $past(rd_port)) // [RQ4]
      else $error("data read wrong");
   a_dir_reads: assert property (@(posedge sys_clk) disable iff (!rstn)
      (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `PIO6_DIR_OFS))
      |=> s_axi_rdata == 32'h0000_00ff) // [RQ11]
      else $error("direction read not all ones");
   a_in_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rd_port & ~port_six_direction) == (pin_s2 & ~port_six_direction)) // [RQ2]
      else $error("input bit not pin level");
   a_out_store: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rd_port & port_six_direction) == (port_six_output_value & port_six_direction)) // [RQ3]
      else $error("output bit not stored value");
   a_hwstb_init: assert property (@(posedge sys_clk) disable iff (!rstn)
      hw_standby |=> port_six_output_value == 7'h00 && port_six_direction == 7'h00) // [RQ5]
      else $error("standby did not reinitialise");
   a_swstb_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sw_standby && !hw_standby) |=> $stable(port_six_output_value)) // [RQ6]
      else $error("software standby changed data");
   a_release_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
      (expanded && bus_release_enable) |-> pin_oe[2] && !pin_oe[1]
      && bus_request_in == pin_s2[1]) // [RQ8]
      else $error("bus release pins wrong");
   a_wait_pin: assert property (@(posedge sys_clk) disable iff (!rstn)
      wait_sel |-> !pin_oe[0] && wait_in == pin_s2[0]) // [RQ9]
      else $error("wait pin wrong");
   a_single_gpio: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!expanded && !wait_sel) |-> pin_oe == port_six_direction
      && pin_out == port_six_output_value) // [RQ10]
      else $error("single-chip pin not plain io");
endmodule : pio6_port

// file: pio6_defs.svh
// Offsets, field positions and reset values for the seven-pin port with bus strobes.
// Included by the package user; holds definitions only.
`ifndef PIO6_DEFS_SVH
`define PIO6_DEFS_SVH
`define PIO6_DIR_OFS 12'h0c8
`define PIO6_DATA_OFS 12'h0cc
`define PIO6_CTRL_OFS 12'h0d0
`define PIO6_RST_VAL 8'h80
`define PIO6_RSV_BIT 7
`define PIO6_MODE_SINGLE 3'h7
`define PIO6_MODE_RST 3'h7
`define PIO6_WCE_ALL 8'hff
`define PIO6_WCE_RST 8'hff
`endif

// file: pio6_pkg.sv
// Types shared by the port block.
// Assumes nothing of its surroundings.
package pio6_pkg;
   typedef enum logic [1:0] {pio6_idle, pio6_wresp, pio6_rresp} pio6_bus_e;
   typedef logic [6:0] pio6_pins_t;
endpackage : pio6_pkg

// file: pio6_board.sv
// Board model for the seven port pins and the external bus devices.
// Assumes the port drives a pin where pin_oe is high; the bench sets ext_level elsewhere.
`timescale 1ns/10ps
module pio6_board (
   // From the port.
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe,
   // Drive of outside devices, bus request and wait among them.
   input wire logic [6:0] ext_level,
   // To the port.
   output logic [6:0] pin_in
);
   // An undriven pin shows the outside level, never a stale copy of the port output.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pio6_board

// file: tb.sv
// Self-checking bench for the seven-pin port: AXI4-Lite registers, pin muxing, standby.
// Assumes the board model closes the pin loop; ctl stands for the bus controller strobes.
`timescale 1ns/10ps
`include "pio6_defs.svh"
module tb;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic hw_standby = 1'b0;
   logic sw_standby = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic [4:0] ctl = 5'h00;
   logic [6:0] ext = 7'h00;
   logic bus_request_in, wait_in;
   logic [6:0] pin_in, pin_out, pin_oe, d, v;
   logic [31:0] rd_data;
   logic [31:0] wc [2] = '{32'h0000fe07, 32'h0000ff27};
   int error_cnt = 0;
   int total_checks = 0;
   always #10 sys_clk = ~sys_clk;
   pio6_port i_pio6_port (.sys_clk, .rstn, .hw_standby, .sw_standby, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready(1'b1), .low_byte_write_strobe(ctl[4]), .high_byte_write_strobe(ctl[3]),
      .read_strobe(ctl[2]), .address_strobe(ctl[1]), .bus_grant_ack(ctl[0]),
      .bus_request_in, .wait_in, .pin_in, .pin_out, .pin_oe);
   pio6_board i_pio6_board (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
   function automatic logic [31:0] exp_rd(input logic [6:0] dd, vv, ee);
      return {24'h000000, 1'b1, (dd & vv) | (~dd & ee)};
   endfunction : exp_rd
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic give_up(input int n);
      if (n >= 50) begin
         error_cnt++;
         wrap_up();
      end
   endtask : give_up
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] x);
      int n;
      logic pa, pw;
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while ((pa || pw) && n < 50) begin
         @(posedge sys_clk);
         n++;
         if (pa && s_axi_awready === 1'b1) begin
            pa = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (pw && s_axi_wready === 1'b1) begin
            pw = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge sys_clk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      wr_resp = s_axi_bresp;
      give_up(n);
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 50);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      give_up(n);
   endtask : axi_rd
   initial begin
      void'($urandom(32'hb399));
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      axi_rd(`PIO6_DATA_OFS);
      chk("data", 32'h80, rd_data);
      axi_rd(`PIO6_DIR_OFS);
      chk("dir", 32'hff, rd_data);
      chk("oe", 32'h0, pin_oe);
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 7'h7f : 7'($urandom);
         v = 7'($urandom);
         ext <= 7'($urandom);
         axi_wr(`PIO6_DIR_OFS, {25'h0, d});
         axi_wr(`PIO6_DATA_OFS, {24'h0, ~v[0], v}); // Bit 7 driven to a random value.
         chk("bresp", 32'h0, wr_resp);
         repeat (4) @(posedge sys_clk);
         axi_rd(`PIO6_DATA_OFS);
         chk("data", exp_rd(d, v, ext), rd_data);
         chk("rresp", 32'h0, rd_resp);
         chk("oe", d, pin_oe);
         chk("out", d & v, pin_out & pin_oe);
      end
      sw_standby <= 1'b1;
      axi_wr(`PIO6_DATA_OFS, {25'h0, ~v});
      axi_wr(`PIO6_DIR_OFS, {25'h0, ~d});
      axi_rd(`PIO6_DATA_OFS);
      chk("data", exp_rd(d, v, ext), rd_data);
      chk("oe", d, pin_oe);
      sw_standby <= 1'b0;
      hw_standby <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("oe", 32'h0, pin_oe);
      hw_standby <= 1'b0;
      axi_rd(`PIO6_DATA_OFS);
      chk("data", exp_rd(7'h00, v, ext), rd_data);
      // With every pin an output the stored value shows: standby must have cleared it.
      axi_wr(`PIO6_DIR_OFS, 32'h7f);
      axi_rd(`PIO6_DATA_OFS);
      chk("data", 32'h80, rd_data);
      for (int m = 1; m < 7; m++) begin
         d = 7'($urandom);
         axi_wr(`PIO6_DIR_OFS, {25'h0, d});
         axi_wr(`PIO6_CTRL_OFS, 32'h0000ff10 | 32'(m));
         ctl <= 5'($urandom);
         ext <= 7'($urandom);
         repeat (4) @(posedge sys_clk);
         chk("oe", 6'b111110, pin_oe[6:1]);
         chk("out", ctl, pin_out[6:2]);
         chk("request", ext[1], bus_request_in);
         axi_wr(`PIO6_CTRL_OFS, 32'h0000ff00 | 32'(m));
         chk("oe", d[2:1], pin_oe[2:1]);
         axi_rd(`PIO6_CTRL_OFS);
         chk("ctrl", 32'h0000ff00 | 32'(m), rd_data);
      end
      // A reset in mid-run must bring back single-chip mode with every pin an input.
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk("oe", 32'h0, pin_oe);
      axi_rd(`PIO6_CTRL_OFS);
      chk("ctrl", 32'h0000ff07, rd_data);
      axi_wr(`PIO6_DIR_OFS, 32'h7f);
      axi_rd(`PIO6_DATA_OFS);
      chk("data", 32'h80, rd_data);
      // The direction of pin 0 stays 0 while the wait input is selected.
      axi_wr(`PIO6_DIR_OFS, 32'h7e);
      for (int k = 0; k < 2; k++) begin
         axi_wr(`PIO6_CTRL_OFS, wc[k]);
         ext <= 7'($urandom);
         repeat (4) @(posedge sys_clk);
         chk("wait", ext[0], wait_in);
      end
      axi_wr(`PIO6_CTRL_OFS, 32'h0000ff07);
      chk("wait", 32'h1, wait_in);
      axi_rd(12'h0d4);
      chk("rresp", 32'h2, rd_resp);
      chk("rdata", 32'h0, rd_data);
      axi_wr(12'h0d4, 32'h1);
      chk("bresp", 32'h2, wr_resp);
      wrap_up();
   end
endmodule : tb
